// >>> include/fcdma_pkg.sv
// Shared constants, types and helper functions of the four-channel DMA engine
package fcdma_pkg;
	// ==========================================================
	// Geometry and register blocks
	localparam int         NCH      = 4;
	localparam logic [3:0] BLK_CRC  = 4'hE;
	localparam logic [3:0] BLK_GLB  = 4'hF;
	localparam logic [2:0] OWN_CRC  = 3'h4;
	// Channel register offsets
	localparam logic [7:0] OFS_CSR  = 8'h00;
	localparam logic [7:0] OFS_SAR  = 8'h04;
	localparam logic [7:0] OFS_DAR  = 8'h08;
	localparam logic [7:0] OFS_BCR  = 8'h0C;
	localparam logic [7:0] OFS_CSAR = 8'h14;
	localparam logic [7:0] OFS_CDAR = 8'h18;
	localparam logic [7:0] OFS_CBCR = 8'h1C;
	localparam logic [7:0] OFS_IER  = 8'h20;
	localparam logic [7:0] OFS_ISR  = 8'h24;
	// Checksum block extras
	localparam logic [7:0] OFS_WDAT = 8'h80;
	localparam logic [7:0] OFS_SEED = 8'h84;
	localparam logic [7:0] OFS_SUM  = 8'h88;
	// Global block
	localparam logic [7:0] OFS_GCR  = 8'h00;
	localparam logic [7:0] OFS_SS0  = 8'h04;
	localparam logic [7:0] OFS_SS1  = 8'h08;
	localparam logic [7:0] OFS_GISR = 8'h0C;
	// ==========================================================
	// Field positions
	localparam int B_EN    = 0;
	localparam int B_SRST  = 1;
	localparam int B_MODE  = 2;
	localparam int B_SAD   = 4;
	localparam int B_DAD   = 6;
	localparam int B_WID   = 19;
	localparam int B_TRIG  = 23;
	localparam int B_ERR   = 0;
	localparam int B_DONE  = 1;
	localparam int B_CLKEN = 9;
	localparam int B_IRVS  = 24;
	localparam int B_ORVS  = 25;
	localparam int B_ICOM  = 26;
	localparam int B_OCOM  = 27;
	localparam int B_WLEN  = 28;
	localparam int B_POLY  = 30;
	localparam int B_GCRC  = 16;
	// ==========================================================
	// Reset values
	localparam logic [31:0] RST_CCTL = 32'h2000_0000;
	localparam logic [31:0] RST_SEED = 32'hFFFF_FFFF;
	localparam logic [31:0] RST_SS0  = 32'h1F1F_1F00;
	localparam logic [31:0] RST_SS1  = 32'h0000_001F;
	localparam logic [1:0]  RST_IER  = 2'h1;
	// ==========================================================
	// Encodings
	localparam logic [1:0] MODE_M2M = 2'h0;
	localparam logic [1:0] MODE_P2M = 2'h1;
	localparam logic [1:0] MODE_M2P = 2'h2;
	localparam logic [1:0] DIR_FIX  = 2'h2;
	localparam logic [1:0] DIR_WRAP = 2'h3;
	localparam logic [1:0] WID_WORD = 2'h0;
	localparam logic [1:0] WID_BYTE = 2'h1;
	localparam logic [1:0] WLEN_8   = 2'h0;
	localparam logic [1:0] WLEN_16  = 2'h1;
	localparam logic [1:0] POLY_C8  = 2'h1;
	localparam logic [1:0] POLY_C16 = 2'h2;
	localparam logic [1:0] POLY_C32 = 2'h3;
	// ==========================================================
	// Controller registers and far-side memory map
	localparam logic [7:0] HA_CADR  = 8'h00;
	localparam logic [7:0] HA_CDAT  = 8'h04;
	localparam logic [7:0] HA_CMD   = 8'h08;
	localparam logic [7:0] HA_CRD   = 8'h0C;
	localparam logic [7:0] HA_PER   = 8'h10;
	localparam logic [1:0] HA_MEMW  = 2'h1;
	localparam logic [3:0] MAP_PER  = 4'h4;
	localparam int         MEM_WDS  = 16;
	// ==========================================================
	// Types
	typedef enum logic {M_IDLE, M_BUSY} fcdma_mst_t;
	typedef struct packed {
		logic        en;
		logic [1:0]  mode;
		logic [1:0]  wid;
		logic [1:0]  sad;
		logic [1:0]  dad;
		logic        trig;
		logic [31:0] sar;
		logic [31:0] dar;
		logic [15:0] bcr;
		logic [31:0] csar;
		logic [31:0] cdar;
		logic [15:0] cbcr;
		logic [1:0]  ier;
		logic        done;
		logic        err;
		logic        full;
		logic [31:0] buff;
	} fcdma_ch_t;
	localparam fcdma_ch_t CH_RST = '{ier: RST_IER, default: '0};
	// ==========================================================
	// Helpers
	function automatic logic [31:0] adv_addr(input logic [31:0] a, input logic [1:0] dir,
		input logic [2:0] step);
		return (dir == DIR_FIX) ? a : a + {29'h0, step};
	endfunction
	function automatic logic [2:0] step_bytes(input logic [1:0] mode, input logic [1:0] wid);
		if (mode == MODE_M2M || wid == WID_WORD) return 3'h4;
		return (wid == WID_BYTE) ? 3'h1 : 3'h2;
	endfunction
	function automatic logic [5:0] crc_w(input logic [1:0] p);
		case (p)
			POLY_C8:  return 6'h08;
			POLY_C32: return 6'h20;
			default:  return 6'h10;
		endcase
	endfunction
	function automatic logic [31:0] crc_p(input logic [1:0] p);
		case (p)
			POLY_C8:  return 32'h0000_0007;
			POLY_C16: return 32'h0000_8005;
			POLY_C32: return 32'h04C1_1DB7;
			default:  return 32'h0000_1021;
		endcase
	endfunction
	function automatic logic [31:0] rev32(input logic [31:0] d);
		logic [31:0] r;
		for (int i = 0; i < 32; i++) r[i] = d[31-i];
		return r;
	endfunction
	// State is kept left-aligned so one shifter serves every width
	function automatic logic [31:0] crc_byte(input logic [31:0] s, input logic [7:0] b,
		input logic [31:0] pa);
		logic [31:0] t;
		logic        fb;
		t = s;
		for (int i = 7; i >= 0; i--) begin
			fb = t[31] ^ b[i];
			t  = {t[30:0], 1'h0} ^ (fb ? pa : 32'h0);
		end
		return t;
	endfunction
endpackage

// >>> include/fcdma_if.sv
// Carrier between the DMA engine and its controller / system bus end
`timescale 1ns/1ps
interface fcdma_if;
	logic        reg_sel;
	logic        reg_wr;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic        reg_ack;
	logic        m_req;
	logic        m_we;
	logic [31:0] m_addr;
	logic [31:0] m_wdata;
	logic [1:0]  m_size;
	logic [31:0] m_rdata;
	logic        m_ack;
	logic        m_err;
	logic [3:0]  preq;
	modport dev (input reg_sel, reg_wr, reg_addr, reg_wdata, output reg_rdata, reg_ack,
		output m_req, m_we, m_addr, m_wdata, m_size, input m_rdata, m_ack, m_err, input preq);
	modport host (output reg_sel, reg_wr, reg_addr, reg_wdata, input reg_rdata, reg_ack,
		input m_req, m_we, m_addr, m_wdata, m_size, output m_rdata, m_ack, m_err, output preq);
endinterface

// >>> logic/fcdma_engine.sv
// Four-channel DMA engine with checksum channel
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module fcdma_engine import fcdma_pkg::*; (
	input  logic       i_mclk,
	input  logic       i_rst,
	fcdma_if.dev       bus,
	output logic       o_irq,
	output logic [4:0] o_busy
);
	// ==========================================================
	// State
	fcdma_ch_t   ch_r [NCH];
	fcdma_ch_t   ch_nxt [NCH];
	logic [31:0] gcr_r, gcr_nxt, ss0_r, ss0_nxt, ss1_r, ss1_nxt;
	logic [31:0] cctl_r, cctl_nxt, cseed_r, cseed_nxt, cst_r, cst_nxt;
	logic [31:0] csa_r, csa_nxt, ccsa_r, ccsa_nxt, cwd_r, cwd_nxt, cq_r, cq_nxt;
	logic [15:0] cbc_r, cbc_nxt, ccbc_r, ccbc_nxt;
	logic [2:0]  cn_r, cn_nxt;
	logic [1:0]  cier_r, cier_nxt;
	logic        cdone_r, cdone_nxt;
	fcdma_mst_t  mst_r, mst_nxt;
	logic [2:0]  own_r, own_nxt;
	logic        mwe_r, mwe_nxt;
	logic [31:0] maddr_r, maddr_nxt, mwdata_r, mwdata_nxt;
	logic [1:0]  msize_r, msize_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic        ack_r, ack_nxt;
	// ==========================================================
	// Helpers
	logic [3:0]  blk;
	logic [7:0]  ofs;
	logic [1:0]  rc, oc, gc;
	logic [4:0]  need;
	logic [2:0]  gnt, ost, take;
	logic [15:0] ncnt;
	logic [5:0]  cw, csh, nsh;
	logic [31:0] raw, rvs, sum, pal, rb;
	logic [7:0]  ib;
	logic [3:0]  clken;
	logic        cset;

	assign blk   = bus.reg_addr[11:8];
	assign ofs   = bus.reg_addr[7:0];
	assign rc    = 2'(blk - 4'h1);
	assign oc    = own_r[1:0];
	assign gc    = gnt[1:0];
	assign clken = gcr_r[B_CLKEN +: NCH];
	assign ost   = step_bytes(ch_r[oc].mode, ch_r[oc].wid);
	assign ncnt  = (ch_r[oc].cbcr > {13'h0, ost}) ? ch_r[oc].cbcr - {13'h0, ost} : 16'h0;
	assign take  = (ccbc_r >= 16'h0004) ? 3'h4 : ccbc_r[2:0];
	assign cset  = (cn_r == 3'h1) & cctl_r[B_TRIG] & (ccbc_r == 16'h0);
	assign cw    = crc_w(cctl_r[B_POLY +: 2]);
	assign csh   = 6'h20 - cw;
	assign nsh   = 6'h20 - crc_w(bus.reg_wdata[B_POLY +: 2]);
	assign pal   = crc_p(cctl_r[B_POLY +: 2]) << csh;
	assign rb    = rev32({cq_r[7:0], 24'h0});
	assign ib    = (cctl_r[B_IRVS] ? rb[7:0] : cq_r[7:0]) ^ {8{cctl_r[B_ICOM]}};
	assign raw   = cst_r >> csh;
	assign rvs   = cctl_r[B_ORVS] ? (rev32(raw) >> csh) : raw;
	assign sum   = cctl_r[B_OCOM] ? rvs ^ (32'hFFFF_FFFF >> csh) : rvs;

	// Peripheral side waits for the peripheral's request line
	always_comb begin
		for (int k = 0; k < NCH; k++) begin
			need[k] = ch_r[k].en & ch_r[k].trig & ~ch_r[k].err & clken[k]
				& (bus.preq[k] | (ch_r[k].full ? ch_r[k].mode != MODE_M2P
				: ch_r[k].mode != MODE_P2M));
		end
		need[4] = cctl_r[B_EN] & cctl_r[B_TRIG] & (cn_r == 3'h0) & (ccbc_r != 16'h0);
		gnt = 3'h0;
		for (int k = 4; k >= 0; k--) begin
			if (need[k]) gnt = 3'(k);
		end
	end

	// ==========================================================
	// Next state
	always_comb begin
		ch_nxt = ch_r;
		gcr_nxt = gcr_r; ss0_nxt = ss0_r; ss1_nxt = ss1_r;
		cctl_nxt = cctl_r; cseed_nxt = cseed_r; cst_nxt = cst_r; csa_nxt = csa_r;
		ccsa_nxt = ccsa_r; cwd_nxt = cwd_r; cq_nxt = cq_r; cbc_nxt = cbc_r;
		ccbc_nxt = ccbc_r; cn_nxt = cn_r; cier_nxt = cier_r; cdone_nxt = cdone_r;
		mst_nxt = mst_r; own_nxt = own_r; mwe_nxt = mwe_r; maddr_nxt = maddr_r;
		mwdata_nxt = mwdata_r; msize_nxt = msize_r;
		rd_nxt = rd_r;
		ack_nxt = 1'h0;
		// Checksum byte stepper, one byte per clock
		if (cn_r != 3'h0) begin
			cst_nxt = crc_byte(cst_r, ib, pal);
			cq_nxt = cq_r >> 8;
			cn_nxt = cn_r - 3'h1;
			if (cset) begin
				cdone_nxt = 1'h1;
				cctl_nxt[B_TRIG] = 1'h0;
			end
		end
		// Register port: answer one cycle after select
		if (bus.reg_sel && !ack_r) begin
			ack_nxt = 1'h1;
			rd_nxt = 32'h0;
			if (blk >= 4'h1 && blk <= 4'h4) begin
				case (ofs)
					OFS_CSR: begin
						rd_nxt = {8'h0, ch_r[rc].trig, 2'h0, ch_r[rc].wid, 11'h0,
							ch_r[rc].dad, ch_r[rc].sad, ch_r[rc].mode, 1'h0, ch_r[rc].en};
						if (bus.reg_wr) begin
							ch_nxt[rc].en = bus.reg_wdata[B_EN];
							ch_nxt[rc].mode = bus.reg_wdata[B_MODE +: 2];
							ch_nxt[rc].sad = bus.reg_wdata[B_SAD +: 2];
							ch_nxt[rc].dad = bus.reg_wdata[B_DAD +: 2];
							ch_nxt[rc].wid = bus.reg_wdata[B_WID +: 2];
							if (bus.reg_wdata[B_TRIG]) begin
								ch_nxt[rc].trig = 1'h1;
								ch_nxt[rc].csar = ch_r[rc].sar;
								ch_nxt[rc].cdar = ch_r[rc].dar;
								ch_nxt[rc].cbcr = ch_r[rc].bcr;
								ch_nxt[rc].full = 1'h0;
							end
							if (bus.reg_wdata[B_SRST]) begin
								// Enable clears with the engine state; the other control fields survive
								ch_nxt[rc].en = 1'h0;
								ch_nxt[rc].trig = 1'h0;
								ch_nxt[rc].full = 1'h0;
								ch_nxt[rc].cbcr = 16'h0;
							end
						end
					end
					OFS_SAR: begin
						rd_nxt = ch_r[rc].sar;
						if (bus.reg_wr) ch_nxt[rc].sar = {bus.reg_wdata[31:2], 2'h0};
					end
					OFS_DAR: begin
						rd_nxt = ch_r[rc].dar;
						if (bus.reg_wr) ch_nxt[rc].dar = {bus.reg_wdata[31:2], 2'h0};
					end
					OFS_BCR: begin
						rd_nxt = {16'h0, ch_r[rc].bcr};
						if (bus.reg_wr) ch_nxt[rc].bcr = bus.reg_wdata[15:0];
					end
					OFS_CSAR: rd_nxt = ch_r[rc].csar;
					OFS_CDAR: rd_nxt = ch_r[rc].cdar;
					OFS_CBCR: rd_nxt = {16'h0, ch_r[rc].cbcr};
					OFS_IER: begin
						rd_nxt = {30'h0, ch_r[rc].ier};
						if (bus.reg_wr) ch_nxt[rc].ier = bus.reg_wdata[1:0];
					end
					OFS_ISR: begin
						rd_nxt = {30'h0, ch_r[rc].done, ch_r[rc].err};
						if (bus.reg_wr && bus.reg_wdata[B_DONE]) ch_nxt[rc].done = 1'h0;
						if (bus.reg_wr && bus.reg_wdata[B_ERR]) ch_nxt[rc].err = 1'h0;
					end
					default: rd_nxt = 32'h0;
				endcase
			end else if (blk == BLK_CRC) begin
				case (ofs)
					OFS_CSR: begin
						rd_nxt = cctl_r;
						if (bus.reg_wr) begin
							cctl_nxt = bus.reg_wdata & 32'hFF80_0001;
							// Seed aligned for the polynomial written alongside
							if (bus.reg_wdata[B_SRST]) cst_nxt = cseed_r << nsh;
							if (bus.reg_wdata[B_TRIG]) begin
								ccsa_nxt = csa_r;
								ccbc_nxt = cbc_r;
							end
						end
					end
					OFS_SAR: begin
						rd_nxt = csa_r;
						if (bus.reg_wr) csa_nxt = {bus.reg_wdata[31:2], 2'h0};
					end
					OFS_BCR: begin
						rd_nxt = {16'h0, cbc_r};
						if (bus.reg_wr) cbc_nxt = bus.reg_wdata[15:0];
					end
					OFS_CSAR: rd_nxt = ccsa_r;
					OFS_CBCR: rd_nxt = {16'h0, ccbc_r};
					OFS_IER: begin
						rd_nxt = {30'h0, cier_r};
						if (bus.reg_wr) cier_nxt = bus.reg_wdata[1:0];
					end
					OFS_ISR: begin
						rd_nxt = {30'h0, cdone_r, 1'h0};
						// Set wins over a clear in the same cycle
						if (bus.reg_wr && bus.reg_wdata[B_DONE] && !cset) cdone_nxt = 1'h0;
					end
					OFS_WDAT: begin
						rd_nxt = cwd_r;
						if (bus.reg_wr && cctl_r[B_EN] && !cctl_r[B_TRIG]) begin
							cwd_nxt = bus.reg_wdata;
							cq_nxt = bus.reg_wdata;
							cn_nxt = (cctl_r[B_WLEN +: 2] == WLEN_8) ? 3'h1
								: (cctl_r[B_WLEN +: 2] == WLEN_16) ? 3'h2 : 3'h4;
						end
					end
					OFS_SEED: begin
						rd_nxt = cseed_r;
						if (bus.reg_wr) cseed_nxt = bus.reg_wdata;
					end
					OFS_SUM: rd_nxt = sum;
					default: rd_nxt = 32'h0;
				endcase
			end else if (blk == BLK_GLB) begin
				case (ofs)
					OFS_GCR: begin
						rd_nxt = gcr_r;
						if (bus.reg_wr) gcr_nxt = bus.reg_wdata;
					end
					OFS_SS0: begin
						rd_nxt = ss0_r;
						if (bus.reg_wr) ss0_nxt = bus.reg_wdata;
					end
					OFS_SS1: begin
						rd_nxt = ss1_r;
						if (bus.reg_wr) ss1_nxt = bus.reg_wdata;
					end
					OFS_GISR: begin
						for (int k = 0; k < NCH; k++) rd_nxt[k] = ch_r[k].done | ch_r[k].err;
						rd_nxt[B_GCRC] = cdone_r;
					end
					default: rd_nxt = 32'h0;
				endcase
			end
		end
		// Bus completion; hardware sets land after software clears
		if (mst_r == M_BUSY && bus.m_ack) begin
			mst_nxt = M_IDLE;
			if (own_r == OWN_CRC) begin
				if (bus.m_err) cctl_nxt[B_TRIG] = 1'h0;
				else begin
					cq_nxt = bus.m_rdata;
					cn_nxt = take;
					ccsa_nxt = ccsa_r + 32'h4;
					ccbc_nxt = ccbc_r - {13'h0, take};
				end
			end else if (bus.m_err) begin
				ch_nxt[oc].err = 1'h1;
				ch_nxt[oc].trig = 1'h0;
				ch_nxt[oc].full = 1'h0;
			end else if (!mwe_r) begin
				// Read landing after disable is dropped
				ch_nxt[oc].buff = bus.m_rdata;
				ch_nxt[oc].full = ch_r[oc].en;
				ch_nxt[oc].csar = adv_addr(ch_r[oc].csar, ch_r[oc].sad, ost);
			end else begin
				ch_nxt[oc].full = 1'h0;
				ch_nxt[oc].cdar = adv_addr(ch_r[oc].cdar, ch_r[oc].dad, ost);
				ch_nxt[oc].cbcr = ncnt;
				if (ncnt == 16'h0) begin
					ch_nxt[oc].done = 1'h1;
					if (ch_r[oc].sad == DIR_WRAP || ch_r[oc].dad == DIR_WRAP) begin
						ch_nxt[oc].csar = ch_r[oc].sar;
						ch_nxt[oc].cdar = ch_r[oc].dar;
						ch_nxt[oc].cbcr = ch_r[oc].bcr;
					end else begin
						ch_nxt[oc].trig = 1'h0;
					end
				end
			end
		end
		// Grant only from idle: one access per ownership
		if (mst_r == M_IDLE && need != 5'h0) begin
			mst_nxt = M_BUSY;
			own_nxt = gnt;
			if (gnt == OWN_CRC) begin
				mwe_nxt = 1'h0;
				maddr_nxt = ccsa_r;
				msize_nxt = WID_WORD;
			end else begin
				mwe_nxt = ch_r[gc].full;
				maddr_nxt = ch_r[gc].full ? ch_r[gc].cdar : ch_r[gc].csar;
				mwdata_nxt = ch_r[gc].buff;
				msize_nxt = (ch_r[gc].mode == MODE_M2M) ? WID_WORD : ch_r[gc].wid;
			end
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			for (int k = 0; k < NCH; k++) ch_r[k] <= CH_RST;
			gcr_r <= 32'h0; ss0_r <= RST_SS0; ss1_r <= RST_SS1;
			cctl_r <= RST_CCTL; cseed_r <= RST_SEED; cst_r <= RST_SEED;
			csa_r <= 32'h0; ccsa_r <= 32'h0; cwd_r <= 32'h0; cq_r <= 32'h0;
			cbc_r <= 16'h0; ccbc_r <= 16'h0; cn_r <= 3'h0; cier_r <= RST_IER;
			cdone_r <= 1'h0; mst_r <= M_IDLE; own_r <= 3'h0; mwe_r <= 1'h0;
			maddr_r <= 32'h0; mwdata_r <= 32'h0; msize_r <= 2'h0;
			rd_r <= 32'h0; ack_r <= 1'h0;
		end else begin
			ch_r <= ch_nxt;
			gcr_r <= gcr_nxt; ss0_r <= ss0_nxt; ss1_r <= ss1_nxt;
			cctl_r <= cctl_nxt; cseed_r <= cseed_nxt; cst_r <= cst_nxt;
			csa_r <= csa_nxt; ccsa_r <= ccsa_nxt; cwd_r <= cwd_nxt; cq_r <= cq_nxt;
			cbc_r <= cbc_nxt; ccbc_r <= ccbc_nxt; cn_r <= cn_nxt; cier_r <= cier_nxt;
			cdone_r <= cdone_nxt; mst_r <= mst_nxt; own_r <= own_nxt; mwe_r <= mwe_nxt;
			maddr_r <= maddr_nxt; mwdata_r <= mwdata_nxt; msize_r <= msize_nxt;
			rd_r <= rd_nxt; ack_r <= ack_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign bus.reg_rdata = rd_r;
	assign bus.reg_ack   = ack_r;
	assign bus.m_req     = (mst_r == M_BUSY);
	assign bus.m_we      = mwe_r;
	assign bus.m_addr    = maddr_r;
	assign bus.m_wdata   = mwdata_r;
	assign bus.m_size    = msize_r;
	always_comb begin
		o_irq = cdone_r & cier_r[B_DONE];
		for (int k = 0; k < NCH; k++) begin
			o_irq = o_irq | (ch_r[k].done & ch_r[k].ier[B_DONE])
				| (ch_r[k].err & ch_r[k].ier[B_ERR]);
			o_busy[k] = ch_r[k].en & ch_r[k].trig;
		end
		o_busy[4] = cctl_r[B_EN] & cctl_r[B_TRIG];
	end
endmodule

// >>> logic/fcdma_host.sv
// Controller end: APB command registers, small memory and peripheral data slot
`timescale 1ns/1ps
module fcdma_host import fcdma_pkg::*; (
	input  logic        i_mclk,
	input  logic        i_rst,
	input  logic        i_psel,
	input  logic        i_penable,
	input  logic        i_pwrite,
	input  logic [7:0]  i_paddr,
	input  logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic        o_pready,
	output logic        o_pslverr,
	input  logic [3:0]  i_preq,
	fcdma_if.host       bus
);
	// ==========================================================
	// State
	logic [31:0] mem_r [MEM_WDS];
	logic [31:0] mem_nxt [MEM_WDS];
	logic [31:0] cadr_r, cadr_nxt, cdat_r, cdat_nxt, crd_r, crd_nxt, per_r, per_nxt;
	logic        cbusy_r, cbusy_nxt, cwr_r, cwr_nxt;
	logic [31:0] mrd_r, mrd_nxt, prd_r, prd_nxt;
	logic        mack_r, mack_nxt, merr_r, merr_nxt, prdy_r, prdy_nxt, perr_r, perr_nxt;
	logic        acc, mem_hit, per_hit, apb_mem;

	assign acc     = i_psel & i_penable;
	assign apb_mem = (i_paddr[7:6] == HA_MEMW);
	assign mem_hit = (bus.m_addr[31:6] == 26'h0);
	assign per_hit = (bus.m_addr[31:28] == MAP_PER);

	// ==========================================================
	// Next state
	always_comb begin
		mem_nxt = mem_r;
		cadr_nxt = cadr_r; cdat_nxt = cdat_r; crd_nxt = crd_r; per_nxt = per_r;
		cbusy_nxt = cbusy_r; cwr_nxt = cwr_r; mrd_nxt = mrd_r; prd_nxt = prd_r;
		perr_nxt = perr_r;
		// One wait state so read data comes from a flop
		prdy_nxt = acc & ~prdy_r;
		mack_nxt = 1'h0;
		merr_nxt = 1'h0;
		if (acc && !prdy_r) begin
			perr_nxt = 1'h0;
			case (i_paddr)
				HA_CADR: prd_nxt = cadr_r;
				HA_CDAT: prd_nxt = cdat_r;
				HA_CMD:  prd_nxt = {31'h0, cbusy_r};
				HA_CRD:  prd_nxt = crd_r;
				HA_PER:  prd_nxt = per_r;
				default: begin
					prd_nxt = apb_mem ? mem_r[i_paddr[5:2]] : 32'h0;
					perr_nxt = ~apb_mem;
				end
			endcase
		end
		if (acc && prdy_r && i_pwrite) begin
			case (i_paddr)
				HA_CADR: cadr_nxt = i_pwdata;
				HA_CDAT: cdat_nxt = i_pwdata;
				HA_CMD: begin
					// A command while one is pending is dropped
					if (!cbusy_r && i_pwdata[0]) begin
						cbusy_nxt = 1'h1;
						cwr_nxt = i_pwdata[1];
					end
				end
				HA_PER: per_nxt = i_pwdata;
				default: begin
					if (apb_mem) mem_nxt[i_paddr[5:2]] = i_pwdata;
				end
			endcase
		end
		// Software order (enable, addresses, count, trigger) is kept by the command issuer
		if (cbusy_r && bus.reg_ack) begin
			cbusy_nxt = 1'h0;
			crd_nxt = bus.reg_rdata;
		end
		if (bus.m_req && !mack_r) begin
			mack_nxt = 1'h1;
			if (mem_hit) begin
				mrd_nxt = mem_r[bus.m_addr[5:2]];
				if (bus.m_we) mem_nxt[bus.m_addr[5:2]] = bus.m_wdata;
			end else if (per_hit) begin
				mrd_nxt = per_r;
				if (bus.m_we) per_nxt = bus.m_wdata;
			end else begin
				merr_nxt = 1'h1;
			end
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			for (int k = 0; k < MEM_WDS; k++) mem_r[k] <= 32'h0;
			cadr_r <= 32'h0; cdat_r <= 32'h0; crd_r <= 32'h0; per_r <= 32'h0;
			cbusy_r <= 1'h0; cwr_r <= 1'h0; mrd_r <= 32'h0; prd_r <= 32'h0;
			mack_r <= 1'h0; merr_r <= 1'h0; prdy_r <= 1'h0; perr_r <= 1'h0;
		end else begin
			mem_r <= mem_nxt;
			cadr_r <= cadr_nxt; cdat_r <= cdat_nxt; crd_r <= crd_nxt; per_r <= per_nxt;
			cbusy_r <= cbusy_nxt; cwr_r <= cwr_nxt; mrd_r <= mrd_nxt; prd_r <= prd_nxt;
			mack_r <= mack_nxt; merr_r <= merr_nxt; prdy_r <= prdy_nxt; perr_r <= perr_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign o_prdata      = prd_r;
	assign o_pready      = prdy_r;
	assign o_pslverr     = perr_r & prdy_r;
	assign bus.reg_sel   = cbusy_r;
	assign bus.reg_wr    = cwr_r;
	assign bus.reg_addr  = cadr_r[11:0];
	assign bus.reg_wdata = cdat_r;
	assign bus.m_rdata   = mrd_r;
	assign bus.m_ack     = mack_r;
	assign bus.m_err     = merr_r;
	assign bus.preq      = i_preq;
endmodule

// >>> bench/fcdma_asserts.sv
// Protocol checks on the carrier between the two DMA ends
`timescale 1ns/1ps
module fcdma_asserts (
	input wire logic        i_mclk,
	input wire logic        i_rst,
	input wire logic        m_req,
	input wire logic        m_ack,
	input wire logic        m_err,
	input wire logic [31:0] m_addr,
	input wire logic [1:0]  m_size,
	input wire logic        reg_sel,
	input wire logic        reg_ack
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// ==========================================
	// Memory bus
	req_hold_a: assert property (m_req && !m_ack |=> m_req && $stable(m_addr))
		else $error("request dropped early");
	ack_time_a: assert property ($rose(m_req) |=> m_ack)
		else $error("late answer");
	req_gap_a: assert property (m_ack |=> !m_req)
		else $error("no idle cycle");
	ack_src_a: assert property (m_ack |-> $past(m_req))
		else $error("answer without request");
	err_ack_a: assert property (m_err |-> m_ack)
		else $error("lone error");
	word_align_a: assert property (m_req && m_size == 2'h0 |-> m_addr[1:0] == 2'h0)
		else $error("unaligned word");
	// ==========================================
	// Register port
	reg_ack_a: assert property ($rose(reg_sel) |=> reg_ack)
		else $error("register ack late");
	reg_end_a: assert property (reg_ack |=> !reg_ack && !reg_sel)
		else $error("register access overran");
endmodule

// >>> bench/fcdma_tb.sv
// Bench joining engine and controller over the carrier
`timescale 1ns/1ps
`define CMP(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module fcdma_tb import fcdma_pkg::*; ;
	logic        i_mclk = 0, i_rst = 1, psel = 0, pen = 0, pwr = 0, ck = 0;
	logic [7:0]  padr = 0;
	logic [31:0] pwd = 0, last, d0, d1, prd, exp_v;
	logic [3:0]  preq = 0;
	logic [4:0]  busy;
	logic        prdy, irq;
	int          n_fail = 0, samples_checked = 0, seed = 27011, n;
	logic [31:0] q[$];
	fcdma_if bus_if ();
	fcdma_engine fcdma_engine_inst (.i_mclk(i_mclk), .i_rst(i_rst), .bus(bus_if.dev),
		.o_irq(irq), .o_busy(busy));
	fcdma_host fcdma_host_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy),
		.o_pslverr(), .i_preq(preq), .bus(bus_if.host));
	fcdma_asserts fcdma_asserts_inst (.i_mclk(i_mclk), .i_rst(i_rst), .m_req(bus_if.m_req),
		.m_ack(bus_if.m_ack), .m_err(bus_if.m_err), .m_addr(bus_if.m_addr),
		.m_size(bus_if.m_size), .reg_sel(bus_if.reg_sel), .reg_ack(bus_if.reg_ack));
	always #10 i_mclk = ~i_mclk;
	// ==========================================
	// Bus tasks
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
		@(posedge i_mclk);
		psel <= 1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		ck <= c;
		@(posedge i_mclk);
		pen <= 1;
		do @(posedge i_mclk); while (prdy !== 1'b1);
		last = prd;
		psel <= 0;
		pen <= 0;
		ck <= 0;
	endtask
	// Engine registers are reached only through the command slot
	task rg(input logic w, input logic [11:0] a, input logic [31:0] d);
		apb(1, HA_CADR, {20'h0, a}, 0);
		apb(1, HA_CDAT, d, 0);
		apb(1, HA_CMD, {30'h0, w, 1'b1}, 0);
		n = 0;
		do begin apb(0, HA_CMD, 0, 0); n++; end while (last[0] !== 1'b0 && n < 20);
		if (last[0] !== 1'b0) n_fail++;
	endtask
	task ex(input logic [11:0] a, input logic [31:0] e);
		rg(0, a, 0);
		q.push_back(e);
		apb(0, HA_CRD, 0, 1);
	endtask
	task mx(input int i, input logic [31:0] e);
		q.push_back(e);
		apb(0, 8'h40 + 8'(4 * i), 0, 1);
	endtask
	task go(input logic [11:0] b, input logic [31:0] s, dst, c);
		rg(1, b, 32'h1);
		rg(1, b + 12'h4, s);
		rg(1, b + 12'h8, dst);
		rg(1, b + 12'hC, 32'h8);
		rg(1, b, c);
		n = 0;
		while (busy !== 5'h0 && n < 300) begin @(posedge i_mclk); n++; end
		if (busy !== 5'h0) n_fail++;
	endtask
	// Plain MSB-first shift, bytes low first
	function automatic logic [31:0] crc(input logic [31:0] d);
		logic [31:0] s;
		s = 0;
		for (int i = 0; i < 32; i++)
			s = {s[30:0], 1'b0} ^ ((s[31] ^ d[(i / 8) * 8 + 7 - i % 8]) ? 32'h04C1_1DB7 : 0);
		return s;
	endfunction
	task conclude;
		if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ==========================================
	// Checking and stimulus
	always @(posedge i_mclk) begin
		if (prdy === 1'b1 && ck) begin
			exp_v = q.pop_front();
			`CMP(prd, exp_v)
		end
	end
	initial begin
		#200000;
		n_fail++;
		conclude;
	end
	initial begin
		d0 = $random(seed);
		d1 = $random(seed);
		repeat (3) @(posedge i_mclk);
		i_rst <= 0;
		ex(12'hF04, RST_SS0);
		ex(12'h120, 32'h1);
		rg(1, 12'hF00, 32'h1E00);
		apb(1, 8'h40, d0, 0);
		apb(1, 8'h44, d1, 0);
		go(12'h100, 0, 32'h20, 32'h0080_0001);
		`CMP(irq, 1'b0)
		rg(1, 12'h120, 32'h2);
		`CMP(irq, 1'b1)
		ex(12'h124, 32'h2);
		ex(12'h11C, 32'h0);
		rg(1, 12'h124, 32'h2);
		ex(12'h124, 32'h0);
		go(12'h200, 0, 32'h30, 32'h0080_0081);
		mx(8, d0);
		mx(9, d1);
		mx(12, d1);
		apb(1, HA_PER, ~d0, 0);
		preq <= 4'h8;
		go(12'h400, 32'h4000_0000, 32'h38, 32'h0080_0025);
		preq <= 4'h0;
		ex(12'h414, 32'h4000_0000);
		mx(15, ~d0);
		go(12'h300, 32'h1000_0000, 32'h20, 32'h0080_0001);
		ex(12'h324, 32'h1);
		`CMP(irq, 1'b1)
		rg(1, 12'h324, 32'h1);
		`CMP(irq, 1'b0)
		rg(1, 12'h300, 32'h2);
		ex(12'h300, 32'h0);
		rg(1, 12'hE84, 32'h0);
		rg(1, 12'hE00, 32'hE000_0003);
		ex(12'hE88, 32'h0);
		rg(1, 12'hE80, d0);
		ex(12'hE88, crc(d0));
		rg(1, 12'hE04, 32'h4);
		rg(1, 12'hE0C, 32'h4);
		rg(1, 12'hE00, 32'hE080_0003);
		ex(12'hE24, 32'h2);
		ex(12'hE88, crc(d1));
		conclude;
	end
endmodule
